// ===== verilog/qcp_top.sv
// one quad: crosspoint, pattern generators and checkers behind a wishbone slave
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/100ps

// Functional notes
// - an enabled generator replaces the routed receive data on its transmit lane
// - a checker neither checks nor counts until its enable bit is set
// - the checker reports which of the 7, 9, 15 or 31 stage sequences arrives
// - the checker reports true or complemented polarity of the sequence
// - the checker counts mismatched bits and compared bits
// - pattern restart returns sequence logic to its initial state
// - generator polynomial length is chosen by software
// - generator can instead repeat an 8-bit user pattern, optionally complemented
// - routing is one independent four by four switch matrix per quad
// - after reset, with routing off, each receive lane drives its own transmit lane
// - point-to-point: each chosen receive lane feeds one transmit lane
// - broadcast: one receive lane may feed two, three or four transmit lanes
// - each transmit lane has its own source select
// - each receive lane shows signal detect while a signal is present
// - each transmit path shows lock once its source recovery has locked
module qcp_top #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // receive lanes (pins)
   input  wire logic [3:0]  rx_data_i,
   input  wire logic [3:0]  rx_sigdet_i,
   input  wire logic [3:0]  rx_cdr_lock_i,
   // transmit lanes
   output logic      [3:0]  tx_data_o,
   // equaliser adaptation master
   output logic      [1:0]  bcast_master_o
);
   import qcp_pkg::*;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (CNT_W < 8 || CNT_W > 32) begin : g_bad_cnt
      $error("qcp_top: CNT_W must lie between 8 and 32");
   end

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [11:0]      pin_s1_reg;
   logic [11:0]      pin_s2_reg;
   logic [11:0]      pin_s3_reg;
   logic [11:0]      pin_reg;
   logic [3:0]       rx_bit;
   logic [3:0]       sigdet;
   logic [3:0]       cdr_lock;

   logic [7:0]       ctrl_reg;
   logic [10:0]      xbar_reg;
   logic [11:0]      gen_reg [4];
   logic [3:0]       restart_reg;

   logic             wb_req;
   logic             wr_fire;
   logic [3:0]       page;
   logic [1:0]       idx;
   logic [31:0]      wmask;
   logic [31:0]      rd_data;
   logic [31:0]      ctrl_word;
   logic [31:0]      xbar_word;
   logic [31:0]      ctrl_new;
   logic [31:0]      xbar_new;
   logic [31:0]      gen_new;

   logic [3:0]       gen_en;
   logic [3:0]       chk_en;
   logic             xpt_en;
   logic [1:0]       src_sel [4];
   logic [1:0]       src [4];
   logic [3:0]       gen_bit;
   logic [3:0]       tx_next;
   logic [3:0]       tx_lock;

   qcp_poly_t        chk_poly [4];
   logic [3:0]       chk_inv;
   logic [3:0]       chk_lock;
   logic [CNT_W-1:0] err_cnt [4];
   logic [CNT_W-1:0] bit_cnt [4];

   // merge write data into a register word under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [31:0] m);
      merge = (old_w & ~m) | (new_w & m);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // three stages; a level change is taken once stages two and three agree
   always_ff @(posedge clk_i) begin
      pin_s1_reg <= {rx_cdr_lock_i, rx_sigdet_i, rx_data_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
   end

   // levels need two agreeing stages; serial data bits pass every clock
   // since a one-clock bit would otherwise be swallowed by the filter
   for (genvar b = 0; b < 12; b++) begin : g_pin
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pin_reg[b] <= 1'b0;
         end else if (b < 4 || pin_s2_reg[b] == pin_s3_reg[b]) begin
            pin_reg[b] <= pin_s3_reg[b];
         end
      end
   end

   assign rx_bit   = pin_reg[3:0];
   assign sigdet   = pin_reg[7:4];
   assign cdr_lock = pin_reg[11:8];

   // ---------------------------------------------------------------
   // wishbone decode
   // ---------------------------------------------------------------
   assign wb_req  = wb_cyc_i & wb_stb_i;
   assign wr_fire = wb_req & wb_we_i & wb_ack_o;
   assign page    = wb_adr_i[7:4];
   assign idx     = wb_adr_i[3:2];
   assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   assign ctrl_word = {24'h0, ctrl_reg};
   assign xbar_word = {21'h0, xbar_reg};
   assign ctrl_new  = merge(ctrl_word, wb_dat_i, wmask);
   assign xbar_new  = merge(xbar_word, wb_dat_i, wmask);
   assign gen_new   = merge({16'h0, gen_reg[idx][11:4], 4'h0, gen_reg[idx][3:0]},
                            wb_dat_i, wmask);

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= (wb_req & ~wb_ack_o & ~wb_we_i) ? rd_data : 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   // enables, crosspoint settings and restart pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg    <= QCP_CTRL_RST;
         xbar_reg    <= QCP_XBAR_RST;
         restart_reg <= 4'h0;
      end else begin
         restart_reg <= 4'h0;
         if (wr_fire && page == QCP_PAGE_CTRL && idx == QCP_IDX_CTRL) begin
            ctrl_reg    <= ctrl_new[7:0];
            restart_reg <= ctrl_new[QCP_CTRL_RST_LSB +: 4] & {4{wb_sel_i[1]}};
         end
         if (wr_fire && page == QCP_PAGE_CTRL && idx == QCP_IDX_XBAR) begin
            xbar_reg <= xbar_new[10:0];
         end
      end
   end

   // generator configuration per lane
   for (genvar c = 0; c < 4; c++) begin : g_gcfg
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            gen_reg[c] <= QCP_GEN_RST;
         end else if (wr_fire && page == QCP_PAGE_GEN && idx == 2'(c)) begin
            gen_reg[c] <= {gen_new[QCP_GEN_PAT_LSB +: 8], gen_new[3:0]};
         end
      end
   end

   assign gen_en         = ctrl_reg[QCP_CTRL_GEN_LSB +: 4];
   assign chk_en         = ctrl_reg[QCP_CTRL_CHK_LSB +: 4];
   assign xpt_en         = xbar_reg[QCP_XBAR_EN_BIT];
   assign bcast_master_o = xbar_reg[QCP_XBAR_MST_LSB +: 2];

   // ---------------------------------------------------------------
   // read multiplexer
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0;
      unique case (page)
         QCP_PAGE_CTRL: begin
            if (idx == QCP_IDX_CTRL) rd_data = ctrl_word;
            if (idx == QCP_IDX_XBAR) rd_data = xbar_word;
            if (idx == QCP_IDX_STAT) rd_data = {24'h0, tx_lock, sigdet};
         end
         QCP_PAGE_GEN: begin
            rd_data = {16'h0, gen_reg[idx][11:4], 4'h0, gen_reg[idx][3:0]};
         end
         QCP_PAGE_CHK: begin
            rd_data = {28'h0, chk_lock[idx], chk_inv[idx], chk_poly[idx]};
         end
         QCP_PAGE_ERR: begin
            rd_data = 32'(err_cnt[idx]);
         end
         QCP_PAGE_BIT: begin
            rd_data = 32'(bit_cnt[idx]);
         end
         default: begin
            rd_data = 32'h0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // lanes: generator, checker and crosspoint
   // ---------------------------------------------------------------
   for (genvar c = 0; c < 4; c++) begin : g_lane
      qcp_pat_if pcfg ();

      assign pcfg.en      = gen_en[c];
      assign pcfg.restart = restart_reg[c];
      assign pcfg.poly    = qcp_poly_t'(gen_reg[c][QCP_GEN_POLY_LSB +: 2]);
      assign pcfg.user    = gen_reg[c][QCP_GEN_USER_BIT];
      assign pcfg.inv     = gen_reg[c][QCP_GEN_INV_BIT];
      assign pcfg.pat     = gen_reg[c][11:4];

      qcp_prbs_gen u_gen (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .cfg   (pcfg),
         .bit_o (gen_bit[c])
      );

      qcp_prbs_chk #(
         .CNT_W (CNT_W)
      ) u_chk (
         .clk_i     (clk_i),
         .rst_i     (rst_i),
         .en_i      (chk_en[c]),
         .restart_i (restart_reg[c]),
         .bit_i     (rx_bit[c]),
         .poly_o    (chk_poly[c]),
         .inv_o     (chk_inv[c]),
         .lock_o    (chk_lock[c]),
         .err_cnt_o (err_cnt[c]),
         .bit_cnt_o (bit_cnt[c])
      );

      // any rx may feed any number of tx lanes of this quad
      assign src_sel[c] = xbar_reg[QCP_XBAR_SEL_LSB + 2*c +: 2];
      assign src[c]     = xpt_en ? src_sel[c] : 2'(c);
      assign tx_next[c] = gen_en[c] ? gen_bit[c] : rx_bit[src[c]];
      assign tx_lock[c] = cdr_lock[src[c]];
   end

   // registered transmit lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_data_o <= 4'h0;
      end else begin
         tx_data_o <= tx_next;
      end
   end
endmodule

// ===== verilog/qcp_pkg.sv
// shared constants, types and functions of the quad crosspoint with pattern logic
package qcp_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [3:0] QCP_PAGE_CTRL = 4'h0;   // 0x00 ctrl, 0x04 xbar, 0x08 status
   localparam logic [3:0] QCP_PAGE_GEN  = 4'h1;   // 0x10 + 4*ch generator config
   localparam logic [3:0] QCP_PAGE_CHK  = 4'h2;   // 0x20 + 4*ch checker status
   localparam logic [3:0] QCP_PAGE_ERR  = 4'h3;   // 0x30 + 4*ch error count
   localparam logic [3:0] QCP_PAGE_BIT  = 4'h4;   // 0x40 + 4*ch bit count
   localparam logic [1:0] QCP_IDX_CTRL  = 2'h0;
   localparam logic [1:0] QCP_IDX_XBAR  = 2'h1;
   localparam logic [1:0] QCP_IDX_STAT  = 2'h2;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int QCP_CTRL_GEN_LSB = 0;    // generator enables [3:0]
   localparam int QCP_CTRL_CHK_LSB = 4;    // checker enables [7:4]
   localparam int QCP_CTRL_RST_LSB = 8;    // pattern_restart pulses [11:8]
   localparam int QCP_XBAR_SEL_LSB = 0;    // tx_source_select, 2 bits per tx
   localparam int QCP_XBAR_EN_BIT  = 8;    // crosspoint routing enable
   localparam int QCP_XBAR_MST_LSB = 9;    // broadcast master output [10:9]
   localparam int QCP_STAT_SIG_LSB = 0;    // signal detect per rx [3:0]
   localparam int QCP_STAT_LCK_LSB = 4;    // lock per tx path [7:4]
   localparam int QCP_GEN_POLY_LSB = 0;    // polynomial select [1:0]
   localparam int QCP_GEN_USER_BIT = 2;    // user pattern mode
   localparam int QCP_GEN_INV_BIT  = 3;    // complement output
   localparam int QCP_GEN_PAT_LSB  = 8;    // user pattern [15:8]
   localparam int QCP_CHK_POLY_LSB = 0;    // detected polynomial [1:0]
   localparam int QCP_CHK_INV_BIT  = 2;    // complemented sequence
   localparam int QCP_CHK_LCK_BIT  = 3;    // checker locked

   // ---------------------------------------------------------------
   // reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0]  QCP_CTRL_RST = 8'h00;
   localparam logic [10:0] QCP_XBAR_RST = 11'h0E4;   // identity selects, routing off
   localparam logic [11:0] QCP_GEN_RST  = 12'h000;
   localparam logic [30:0] QCP_SEED     = 31'h7FFFFFFF;
   localparam int          QCP_LOCK_MATCHES = 64;   // matching bits before lock

   typedef enum logic [1:0] {QCP_PRBS7, QCP_PRBS9, QCP_PRBS15, QCP_PRBS31} qcp_poly_t;

   // feedback bit of the chosen polynomial; h[k] is the bit k+1 steps back
   function automatic logic qcp_prbs_fb(input qcp_poly_t p, input logic [30:0] h);
      unique case (p)
         QCP_PRBS7:  qcp_prbs_fb = h[6] ^ h[5];
         QCP_PRBS9:  qcp_prbs_fb = h[8] ^ h[4];
         QCP_PRBS15: qcp_prbs_fb = h[14] ^ h[13];
         QCP_PRBS31: qcp_prbs_fb = h[30] ^ h[27];
      endcase
   endfunction

endpackage

// ===== verilog/qcp_pat_if.sv
// generator configuration carried from the register file to one generator
`timescale 1ns/100ps
interface qcp_pat_if;
   import qcp_pkg::*;
   logic       en;
   logic       restart;
   qcp_poly_t  poly;
   logic       user;
   logic       inv;
   logic [7:0] pat;
   modport ctl (output en, restart, poly, user, inv, pat);
   modport gen (input en, restart, poly, user, inv, pat);
endinterface

// ===== verilog/qcp_prbs_gen.sv
// pattern generator of one transmit channel
`timescale 1ns/100ps
module qcp_prbs_gen (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // configuration
   qcp_pat_if.gen    cfg,
   // generated bit
   output logic      bit_o
);
   import qcp_pkg::*;

   logic [30:0] lfsr_reg;
   logic [30:0] lfsr_next;
   logic [2:0]  idx_reg;
   logic        raw;

   // --------------------------------------------------------------
   // sequence step
   // --------------------------------------------------------------
   assign lfsr_next = {lfsr_reg[29:0], qcp_prbs_fb(cfg.poly, lfsr_reg)};
   assign raw       = cfg.user ? cfg.pat[idx_reg] : lfsr_reg[0];
   assign bit_o     = raw ^ cfg.inv;

   // lfsr and user pattern index advance only while enabled
   always_ff @(posedge clk_i) begin
      if (rst_i || cfg.restart) begin
         lfsr_reg <= QCP_SEED;
         idx_reg  <= 3'h0;
      end else if (cfg.en) begin
         lfsr_reg <= lfsr_next;
         idx_reg  <= idx_reg + 3'h1;
      end
   end
endmodule

// ===== verilog/qcp_prbs_chk.sv
// pattern checker of one receive channel
`timescale 1ns/100ps
module qcp_prbs_chk #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // control
   input  wire logic               en_i,
   input  wire logic               restart_i,
   input  wire logic               bit_i,
   // status
   output qcp_pkg::qcp_poly_t      poly_o,
   output logic                    inv_o,
   output logic                    lock_o,
   output logic [CNT_W-1:0]        err_cnt_o,
   output logic [CNT_W-1:0]        bit_cnt_o
);
   import qcp_pkg::*;

   localparam int RUN_W = $clog2(QCP_LOCK_MATCHES + 1);
   localparam logic [RUN_W-1:0] RUN_TOP = RUN_W'(QCP_LOCK_MATCHES);

   logic [30:0]      hist_reg;
   logic [3:0]       dif;
   logic [3:0]       pol_reg;
   logic [3:0]       hit;
   logic [RUN_W-1:0] run_reg [4];
   qcp_poly_t        first_hit;
   logic             err_bit;

   // --------------------------------------------------------------
   // per polynomial prediction and run of consistent bits
   // --------------------------------------------------------------
   for (genvar p = 0; p < 4; p++) begin : g_poly
      assign dif[p] = bit_i ^ qcp_prbs_fb(qcp_poly_t'(p), hist_reg);
      assign hit[p] = (run_reg[p] == RUN_TOP);
      // run grows while difference keeps one polarity
      always_ff @(posedge clk_i) begin
         if (rst_i || restart_i || !en_i) begin
            run_reg[p] <= '0;
            pol_reg[p] <= 1'b0;
         end else if (run_reg[p] != '0 && dif[p] == pol_reg[p]) begin
            run_reg[p] <= hit[p] ? run_reg[p] : run_reg[p] + 1'b1;
         end else begin
            run_reg[p] <= {{(RUN_W-1){1'b0}}, 1'b1};
            pol_reg[p] <= dif[p];
         end
      end
   end

   // shortest polynomial wins when several agree
   assign first_hit = hit[0] ? QCP_PRBS7 : hit[1] ? QCP_PRBS9 :
                      hit[2] ? QCP_PRBS15 : QCP_PRBS31;
   assign err_bit   = dif[poly_o] != inv_o;

   // history, lock and saturating counters
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         hist_reg  <= '0;
         lock_o    <= 1'b0;
         poly_o    <= QCP_PRBS7;
         inv_o     <= 1'b0;
         err_cnt_o <= '0;
         bit_cnt_o <= '0;
      end else if (en_i) begin
         hist_reg <= {hist_reg[29:0], bit_i};
         if (!lock_o && hit != 4'h0) begin
            lock_o <= 1'b1;
            poly_o <= first_hit;
            inv_o  <= pol_reg[first_hit];
         end
         if (lock_o) begin
            if (~&bit_cnt_o) bit_cnt_o <= bit_cnt_o + 1'b1;
            if (err_bit && ~&err_cnt_o) err_cnt_o <= err_cnt_o + 1'b1;
         end
      end
   end
endmodule

// ===== testbench/qcp_sva.sv
// port assertions of the quad crosspoint with pattern logic
`timescale 1ns/100ps
module qcp_sva #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // lanes
   input wire logic [3:0]  tx_data_o,
   input wire logic [1:0]  bcast_master_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // read answer in progress
   wire rd_ack = wb_ack_o && !wb_we_i;
   // request taken, then a one-cycle acknowledge
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_one_pulse: assert property (s_take |=> s_pulse)
      else $error("ack not a single pulse after a request");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_reset_outputs: assert property (disable iff (1'b0)
      rst_i |=> tx_data_o == 4'h0 && bcast_master_o == 2'h0 && !wb_ack_o)
      else $error("outputs not cleared by reset");
   a_restart_reads0: assert property (rd_ack && wb_adr_i[7:2] == 6'h00 |->
      wb_dat_o[11:8] == 4'h0) else $error("restart field reads nonzero");
   a_stat_upper0: assert property (rd_ack && wb_adr_i[7:2] == 6'h02 |->
      wb_dat_o[31:8] == 24'h0) else $error("status upper bits set");
   a_chk_upper0: assert property (rd_ack && wb_adr_i[7:4] == 4'h2 |->
      wb_dat_o[31:4] == 28'h0) else $error("checker status upper bits set");
   a_cnt_width: assert property (rd_ack && wb_adr_i[7:4] inside {4'h3, 4'h4} |->
      (wb_dat_o >> CNT_W) == 32'h0) else $error("counter wider than its width");
   a_unmapped_zero: assert property (rd_ack && (wb_adr_i >= 8'h50 ||
      wb_adr_i[7:2] == 6'h03) |-> wb_dat_o == 32'h0)
      else $error("unmapped read nonzero");
   a_master_by_write: assert property ($changed(bcast_master_o) |->
      $past(wb_ack_o && wb_we_i)) else $error("master output changed without write");
endmodule
bind qcp_top qcp_sva #(.CNT_W(CNT_W)) u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .tx_data_o(tx_data_o), .bcast_master_o(bcast_master_o));

// ===== testbench/qcp_link_model.sv
// far-end link partner: loops lane 0 back to lane 1 or holds fixed levels
`timescale 1ns/100ps
module qcp_link_model (
   // clock
   input  wire logic       clk_i,
   // bench control
   input  wire logic       loop_i,
   input  wire logic [3:0] hold_i,
   input  wire logic       flip_i,
   // serial lanes
   input  wire logic [3:0] tx_i,
   output logic      [3:0] rx_o
);
   logic [3:0] idle_reg;
   initial idle_reg = 4'h5;
   initial rx_o = 4'h0;
   // unused lanes toggle so no stale level looks like data
   always @(posedge clk_i) begin
      idle_reg <= ~idle_reg;
      rx_o     <= loop_i ? {idle_reg[3:2], tx_i[0] ^ flip_i, idle_reg[0]} : hold_i;
   end
endmodule

// ===== testbench/qcp_top_tb.sv
// self-checking bench of the quad crosspoint with pattern logic
`timescale 1ns/100ps
module qcp_top_tb;
   import qcp_pkg::*;
   typedef struct packed {
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] val;
   } qcp_row_t;
   typedef struct packed {
      logic [10:0] xbar;
      logic [3:0]  rx;
      logic [3:0]  tx;
   } qcp_route_t;
   // ------------------------------
   // tables: reset reads, then write and read-back pairs; then crosspoint routing cases with expected tx levels
   // ------------------------------
   localparam int         NROW = 25;
   localparam logic [7:0] PAT  = 8'hB4;
   localparam qcp_row_t   ROWS [NROW] = '{
      '{1'b0,4'hF,8'h00,32'h0}, '{1'b0,4'hF,8'h04,32'hE4}, '{1'b0,4'hF,8'h08,32'h0},
      '{1'b0,4'hF,8'h10,32'h0}, '{1'b0,4'hF,8'h1C,32'h0}, '{1'b0,4'hF,8'h24,32'h0},
      '{1'b0,4'hF,8'h34,32'h0}, '{1'b0,4'hF,8'h44,32'h0}, '{1'b0,4'hF,8'h0C,32'h0},
      '{1'b0,4'hF,8'h50,32'h0}, '{1'b0,4'hF,8'hFC,32'h0},
      '{1'b1,4'hF,8'h10,32'hFFFFFFFF}, '{1'b0,4'hF,8'h10,32'hFF0F},
      '{1'b1,4'h2,8'h10,32'h0}, '{1'b0,4'hF,8'h10,32'hF},
      '{1'b1,4'hF,8'h10,32'h0}, '{1'b0,4'hF,8'h10,32'h0},
      '{1'b1,4'hF,8'h08,32'hFFFFFFFF}, '{1'b0,4'hF,8'h08,32'h0},
      '{1'b1,4'hF,8'h30,32'hFFFFFFFF}, '{1'b0,4'hF,8'h30,32'h0},
      '{1'b1,4'hF,8'h50,32'hFFFFFFFF}, '{1'b0,4'hF,8'h50,32'h0},
      '{1'b1,4'hF,8'h00,32'hF00}, '{1'b0,4'hF,8'h00,32'h0}};
   localparam qcp_route_t ROUTES [5] = '{
      '{11'h0E4,4'hA,4'hA}, '{11'h01B,4'hA,4'hA}, '{11'h555,4'hA,4'hF},
      '{11'h11B,4'hA,4'h5}, '{11'h17F,4'h8,4'h7}};
   // ------------------------------
   // stimulus and observed signals
   // ------------------------------
   logic        clk_i     = 1'b0;
   logic        rst_i     = 1'b1;
   logic        wb_cyc    = 1'b0;
   logic        wb_stb    = 1'b0;
   logic        wb_we     = 1'b0;
   logic [7:0]  wb_adr    = 8'h00;
   logic [3:0]  wb_sel    = 4'h0;
   logic [31:0] wb_wdat   = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic [3:0]  rx_data;
   logic [3:0]  sigdet    = 4'h0;
   logic [3:0]  cdr_lock  = 4'h0;
   logic [3:0]  tx_data;
   logic [1:0]  bcast;
   logic        loop_en   = 1'b0;
   logic [3:0]  hold      = 4'h0;
   logic        flip      = 1'b0;
   logic [31:0] q;
   logic [15:0] bits;
   logic [2:0]  pv;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc_cnt   = 0;
   always #10 clk_i = ~clk_i;
   qcp_top #(.CNT_W(8)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rx_data_i(rx_data),
      .rx_sigdet_i(sigdet), .rx_cdr_lock_i(cdr_lock), .tx_data_o(tx_data),
      .bcast_master_o(bcast));
   qcp_link_model u_link (
      .clk_i(clk_i), .loop_i(loop_en), .hold_i(hold), .flip_i(flip),
      .tx_i(tx_data), .rx_o(rx_data));
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_sel  <= s;
      wb_adr  <= a;
      wb_wdat <= d;
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, 4'hF, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, 4'hF, a, 32'h0);
      check(q, exp);
   endtask
   task automatic run_row(input int i);
      if (ROWS[i].we) wb(1'b1, ROWS[i].sel, ROWS[i].adr, ROWS[i].val);
      else rd_chk(ROWS[i].adr, ROWS[i].val);
   endtask
   // true when the bit run is some rotation of the user pattern
   function automatic logic rot_ok(input logic [15:0] s, input logic inv);
      logic ok;
      rot_ok = 1'b0;
      for (int r = 0; r < 8; r++) begin
         ok = 1'b1;
         for (int j = 0; j < 16; j++) ok = ok & (s[15-j] === (PAT[(j+r)%8] ^ inv));
         rot_ok = rot_ok | ok;
      end
   endfunction
   // hang guard
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         bad_count++;
         test_done;
      end
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      ticks(3);
      rst_i <= 1'b0;
      for (int i = 0; i < NROW; i++) run_row(i);
      for (int i = 0; i < 5; i++) begin
         hold <= ROUTES[i].rx;
         wr(8'h04, {21'h0, ROUTES[i].xbar});
         ticks(8);
         check({28'h0, tx_data}, {28'h0, ROUTES[i].tx});
         check({30'h0, bcast}, {30'h0, ROUTES[i].xbar[10:9]});
      end
      sigdet   <= 4'h5;
      cdr_lock <= 4'h3;
      ticks(8);
      rd_chk(8'h08, 32'h85);
      loop_en <= 1'b1;
      wr(8'h04, 32'hE4);
      for (int p = 0; p < 8; p++) begin
         pv = p[2:0];
         wr(8'h10, {28'h0, pv[2], 1'b0, pv[1:0]});
         wr(8'h00, 32'h321);
         ticks(200);
         rd_chk(8'h24, {28'h0, 1'b1, pv});
         rd_chk(8'h34, 32'h0);
      end
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h321);
      ticks(200);
      flip <= 1'b1;
      ticks(1);
      flip <= 1'b0;
      ticks(20);
      rd_chk(8'h34, 32'h3);
      ticks(300);
      rd_chk(8'h44, 32'hFF);
      flip <= 1'b1;
      ticks(300);
      rd_chk(8'h34, 32'hFF);
      flip <= 1'b0;
      wr(8'h00, 32'h221);
      rd_chk(8'h34, 32'h0);
      rd_chk(8'h44, 32'h0);
      wr(8'h00, 32'h201);
      ticks(200);
      rd_chk(8'h44, 32'h0);
      wb(1'b0, 4'hF, 8'h24, 32'h0);
      check(q & 32'h8, 32'h0);
      for (int v = 0; v < 2; v++) begin
         wr(8'h10, {16'h0, PAT, 4'h0, v[0], 3'h4});
         wr(8'h00, 32'h1);
         ticks(10);
         for (int j = 0; j < 16; j++) begin
            @(posedge clk_i);
            #1 bits = {bits[14:0], tx_data[0]};
         end
         check({31'h0, rot_ok(bits, v[0])}, 32'h1);
      end
      sigdet   <= 4'h0;
      cdr_lock <= 4'h0;
      rst_i    <= 1'b1;
      ticks(3);
      rst_i <= 1'b0;
      for (int i = 0; i < 11; i++) run_row(i);
      test_done;
   end
endmodule
